// >>> common/ocpa_map.vh
// constants for the output coarse phase adjust stage
// assumes inclusion by the stage modules and the test bench
`ifndef OCPA_MAP_VH
`define OCPA_MAP_VH

// register offsets (word index on the plain port)
`define OCPA_ADDR_W          4
`define OCPA_REG_DIV         4'h0
`define OCPA_REG_HIGH        4'h1
`define OCPA_REG_SHIFT       4'h2
`define OCPA_REG_BUF_CTRL    4'h3
`define OCPA_REG_STATUS      4'h4
`define OCPA_REG_ACTIVE_DIV  4'h5

// buffer control fields
`define OCPA_BUF_DIFF_BIT    0
`define OCPA_BUF_INV_BIT     1
`define OCPA_BUF_SWING_LSB   2
`define OCPA_BUF_CM_LSB      4
`define OCPA_BUF_SUPPLY_LSB  7
`define OCPA_BUF_IMP_LSB     10
`define OCPA_BUF_EN_BIT      12

// supply level codes
`define OCPA_SUP_3V3         3'h0
`define OCPA_SUP_2V5         3'h1
`define OCPA_SUP_1V8         3'h2
`define OCPA_SUP_1V5         3'h3
`define OCPA_SUP_1V2         3'h4

// reset values
`define OCPA_DIV_RST         32'h0000000A
`define OCPA_HIGH_RST        32'h00000000
`define OCPA_BUF_RST         13'h0000

// timing limits in divider clock periods
`define OCPA_MIN_HALF        33'h000000002
`define OCPA_MIN_ADJ_DIV     32'h00000005
`define OCPA_MAX_STEP        34'h100000000

`endif

// >>> src/ocpa_pulse_gen.v
// pulse generator: counts high and low lengths of one output period
// assumes lengths of at least two cycles; high length loaded at period start, low length at the falling edge
`timescale 1ns/1ps
`include "ocpa_map.vh"
module ocpa_pulse_gen (
    // clock and reset
    input  wire        clock,
    input  wire        nrst,
    // period lengths
    input  wire [32:0] high_len,
    input  wire [32:0] low_len,
    // outputs
    output reg         clk_out_q,
    output wire        period_end
);
    reg  [32:0] cnt_q;
    wire        last;

    assign last       = (cnt_q == 33'h000000001);
    assign period_end = last && !clk_out_q;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            clk_out_q <= 1'b0;
            cnt_q     <= 33'h000000001;
        end else if (last) begin
            clk_out_q <= !clk_out_q;
            cnt_q     <= clk_out_q ? low_len : high_len;
        end else begin
            cnt_q <= cnt_q - 33'h000000001;
        end
    end
endmodule

// >>> src/ocpa_buffer.v
// output buffer pin logic: differential or dual single-ended
// assumes settings come from validated registers
`timescale 1ns/1ps
`include "ocpa_map.vh"
module ocpa_buffer (
    // clock and reset
    input  wire        clock,
    input  wire        nrst,
    // settings
    input  wire        diff_mode,
    input  wire        invert_comp,
    input  wire        enable,
    // clock in
    input  wire        clk_in,
    // pins
    output reg         true_output_pin,
    output reg         complement_output_pin
);
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            true_output_pin       <= 1'b0;
            complement_output_pin <= 1'b0;
        end else if (!enable) begin
            true_output_pin       <= 1'b0;
            complement_output_pin <= 1'b0;
        end else begin
            true_output_pin       <= clk_in;
            // differential always complementary; single-ended copy or inverted
            complement_output_pin <= (diff_mode | invert_comp) ? !clk_in : clk_in;
        end
    end
endmodule

// >>> src/ocpa_stage.v
// output stage with coarse phase adjust and buffer control registers
// assumes clock is the fractional divider output; plain register port
//
// Behaviour
// - each stage shifts its own edges independently of other stages
// - adjust by lengthening or trimming high and low pulses in divider cycles
// - never shorter than two cycles high plus two cycles low; here only in a negatively adjusted period is each half below two clamped to two
// - no adjust for divide ratio one to four; here such an adjust is refused and flagged in status
// - one step changes each half by at most two to the 32 cycles
// - signed value, positive longer, applied within one period, clamped
// - symmetric duty: adjustment split about equally over high and low
// - programmed high width: whole adjustment goes to low portion
// - any number of successive adjustments accepted; here one written during the adjusted period is dropped at its end
// - buffer drives one differential or two single-ended signals
// - two-bit swing select in differential mode
// - three-bit common-mode select, software picks permitted subset
// - single-ended pins identical unless complement inversion set
// - single-ended impedance select, four choices per supply
// - single-ended supply levels 1.2V to 3.3V
// - output is divider clock over a 32-bit integer ratio
// - default symmetric duty; high-width count below ratio gives pulses
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "ocpa_map.vh"
module ocpa_stage (
    // clock and reset
    input  wire        clock,
    input  wire        nrst,
    // register port
    input  wire [3:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata,
    // output pins
    output wire        true_output_pin,
    output wire        complement_output_pin,
    // analog buffer settings
    output wire        diff_mode,
    output wire [1:0]  swing_select,
    output wire [2:0]  common_mode_select,
    output wire [2:0]  supply_level_select,
    output wire [1:0]  impedance_select,
    output wire        setting_error
);
    localparam ST_NORMAL = 2'b01;
    localparam ST_ADJUST = 2'b10;

    reg  [31:0] div_q;
    reg  [31:0] high_q;
    reg  [31:0] shift_q;
    reg  [12:0] buf_q;
    reg         pend_q;
    reg         rejected_q;
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [32:0] high_len_q;
    reg  [32:0] low_len_q;
    reg  [32:0] high_d;
    reg  [32:0] low_d;
    reg  [32:0] nom_high;
    reg  [32:0] nom_low;
    reg  [33:0] adj_h;
    reg  [33:0] adj_l;
    reg  [34:0] sum_h;
    reg  [34:0] sum_l;
    wire        period_end;
    wire        clk_div;
    wire        sym;
    wire        adj_ok;
    wire        wr_shift;
    wire [33:0] shift_ext;
    wire [33:0] mag;

    assign sym       = (high_q == 32'h00000000) || (high_q >= div_q);
    assign adj_ok    = (div_q >= `OCPA_MIN_ADJ_DIV);
    assign wr_shift  = wr && (addr == `OCPA_REG_SHIFT);
    assign shift_ext = {{2{shift_q[31]}}, shift_q};
    assign mag       = shift_q[31] ? (34'h000000000 - shift_ext) : shift_ext;

    assign diff_mode           = buf_q[`OCPA_BUF_DIFF_BIT];
    assign swing_select        = buf_q[`OCPA_BUF_SWING_LSB+1:`OCPA_BUF_SWING_LSB];
    assign common_mode_select  = buf_q[`OCPA_BUF_CM_LSB+2:`OCPA_BUF_CM_LSB];
    assign supply_level_select = buf_q[`OCPA_BUF_SUPPLY_LSB+2:`OCPA_BUF_SUPPLY_LSB];
    assign impedance_select    = buf_q[`OCPA_BUF_IMP_LSB+1:`OCPA_BUF_IMP_LSB];
    assign setting_error       = diff_mode && ((supply_level_select == `OCPA_SUP_1V5) ||
                                               (supply_level_select == `OCPA_SUP_1V2));

    // nominal lengths from ratio and duty setting
    always @* begin
        if (div_q < 32'h00000002) begin
            nom_high = 33'h000000001;
            nom_low  = 33'h000000001;
        end else if (sym) begin
            nom_high = {1'b0, div_q} >> 1;
            nom_low  = {1'b0, div_q} - ({1'b0, div_q} >> 1);
        end else begin
            nom_high = {1'b0, high_q};
            nom_low  = {1'b0, div_q} - {1'b0, high_q};
        end
    end

    // one-shot adjusted lengths; halves shortened by a negative adjust are clamped at two cycles
    always @* begin
        adj_h = 34'h000000000;
        adj_l = mag;
        if (sym) begin
            adj_h = mag >> 1;
            adj_l = mag - (mag >> 1);
        end
        if (adj_h > `OCPA_MAX_STEP)
            adj_h = `OCPA_MAX_STEP;
        if (adj_l > `OCPA_MAX_STEP)
            adj_l = `OCPA_MAX_STEP;
        if (shift_q[31]) begin
            sum_h = {2'b00, nom_high} - {1'b0, adj_h};
            sum_l = {2'b00, nom_low} - {1'b0, adj_l};
            if (sum_h[34] || sum_h < {2'b00, `OCPA_MIN_HALF})
                sum_h = {2'b00, `OCPA_MIN_HALF};
            if (sum_l[34] || sum_l < {2'b00, `OCPA_MIN_HALF})
                sum_l = {2'b00, `OCPA_MIN_HALF};
        end else begin
            sum_h = {2'b00, nom_high} + {1'b0, adj_h};
            sum_l = {2'b00, nom_low} + {1'b0, adj_l};
        end
        if (sum_h[34:33] != 2'b00)
            sum_h = {2'b00, 33'h1FFFFFFFF};
        if (sum_l[34:33] != 2'b00)
            sum_l = {2'b00, 33'h1FFFFFFFF};
    end

    // period state: pending adjust taken at the boundary
    always @* begin
        state_d = ST_NORMAL;
        high_d  = nom_high;
        low_d   = nom_low;
        case (state_q)
            ST_NORMAL: begin
                if (pend_q && adj_ok) begin
                    state_d = ST_ADJUST;
                    high_d  = sum_h[32:0];
                    low_d   = sum_l[32:0];
                end
            end
            ST_ADJUST: begin
                state_d = ST_NORMAL;
            end
            default: begin
                state_d = ST_NORMAL;
            end
        endcase
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q    <= ST_NORMAL;
            high_len_q <= 33'h000000001;
            low_len_q  <= 33'h000000001;
        end else if (period_end) begin
            state_q    <= state_d;
            high_len_q <= high_d;
            low_len_q  <= low_d;
        end
    end

    // register writes; a new write during pending replaces the value
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_q      <= `OCPA_DIV_RST;
            high_q     <= `OCPA_HIGH_RST;
            shift_q    <= 32'h00000000;
            buf_q      <= `OCPA_BUF_RST;
            pend_q     <= 1'b0;
            rejected_q <= 1'b0;
        end else begin
            if (wr && addr == `OCPA_REG_DIV)
                div_q <= wdata;
            if (wr && addr == `OCPA_REG_HIGH)
                high_q <= wdata;
            if (wr && addr == `OCPA_REG_BUF_CTRL)
                buf_q <= wdata[12:0];
            if (wr_shift) begin
                shift_q <= wdata;
                pend_q  <= 1'b1;
            end else if (period_end) begin
                pend_q <= 1'b0;
            end
            // a refusal in the cycle of a new write still shows
            if (period_end && pend_q && !adj_ok)
                rejected_q <= 1'b1;
            else if (wr_shift)
                rejected_q <= 1'b0;
        end
    end

    // read data one cycle after the strobe
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            case (addr)
                `OCPA_REG_DIV:        rdata <= div_q;
                `OCPA_REG_HIGH:       rdata <= high_q;
                `OCPA_REG_SHIFT:      rdata <= shift_q;
                `OCPA_REG_BUF_CTRL:   rdata <= {19'h00000, buf_q};
                `OCPA_REG_STATUS:     rdata <= {27'h0000000, setting_error, rejected_q,
                                                state_q[1], pend_q, true_output_pin};
                `OCPA_REG_ACTIVE_DIV: rdata <= high_len_q[31:0] + low_len_q[31:0];
                default:              rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    // per-stage counter keeps adjustments independent
    ocpa_pulse_gen u_gen (
        .clock      (clock),
        .nrst       (nrst),
        .high_len   (high_d),
        .low_len    (low_len_q),
        .clk_out_q  (clk_div),
        .period_end (period_end)
    );

    ocpa_buffer u_buf (
        .clock                 (clock),
        .nrst                  (nrst),
        .diff_mode             (diff_mode),
        .invert_comp           (buf_q[`OCPA_BUF_INV_BIT]),
        .enable                (buf_q[`OCPA_BUF_EN_BIT]),
        .clk_in                (clk_div),
        .true_output_pin       (true_output_pin),
        .complement_output_pin (complement_output_pin)
    );
endmodule

// >>> sim/ocpa_stage_sva.sv
// checker on the stage ports: pulse shapes and buffer settings
// assumes bind to ocpa_stage, one clock, async low reset
`timescale 1ns/1ps
module ocpa_stage_sva (
    // clock and reset
    input wire logic        clock,
    input wire logic        nrst,
    // register port
    input wire logic [3:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    // pins and settings
    input wire logic        true_output_pin,
    input wire logic        complement_output_pin,
    input wire logic        diff_mode,
    input wire logic [1:0]  swing_select,
    input wire logic [2:0]  common_mode_select,
    input wire logic [2:0]  supply_level_select,
    input wire logic [1:0]  impedance_select,
    input wire logic        setting_error
);
    wire  t  = true_output_pin;
    wire  c  = complement_output_pin;
    wire  bw = wr && addr == 4'h3;
    logic seen_q;
    // first high after enable may be cut short
    always @(posedge clock or negedge nrst)
        if (!nrst) seen_q <= 1'b0;
        else if ($fell(t)) seen_q <= 1'b1;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_min_high; seen_q && $rose(t) |=> t; endproperty
    a_min_high: assert property (p_min_high) else $error("short high");
    property p_min_low; $fell(t) |=> !t; endproperty
    a_min_low: assert property (p_min_low) else $error("short low");
    property p_diff; $past(diff_mode) && $changed(t) && !$past(bw, 2) |-> c != t; endproperty
    a_diff: assert property (p_diff) else $error("pins not opposite");
    property p_se; $changed(t) && !$past(bw, 2) |-> $changed(c); endproperty
    a_se: assert property (p_se) else $error("complement not following");
    property p_err; setting_error == (diff_mode && supply_level_select inside {3'h3, 3'h4}); endproperty
    a_err: assert property (p_err) else $error("bad setting flag");
    property p_swing; bw |=> swing_select == $past(wdata[3:2]); endproperty
    a_swing: assert property (p_swing) else $error("swing not taken");
    property p_cm; bw |=> common_mode_select == $past(wdata[6:4]); endproperty
    a_cm: assert property (p_cm) else $error("common mode not taken");
    property p_sup; bw |=> {supply_level_select, impedance_select} == $past({wdata[9:7], wdata[11:10]}); endproperty
    a_sup: assert property (p_sup) else $error("supply or impedance not taken");
    cover property (diff_mode && $changed(t));
    cover property (setting_error);
    cover property (!diff_mode && c != t);
endmodule
bind ocpa_stage ocpa_stage_sva i_ocpa_stage_sva (.clock, .nrst, .addr, .wdata, .wr, .true_output_pin,
    .complement_output_pin, .diff_mode, .swing_select, .common_mode_select, .supply_level_select,
    .impedance_select, .setting_error);

// >>> sim/ocpa_clk_rx.sv
// downstream receiver: measures high and low lengths of each period
// assumes the watched pin is sampled on the stage clock
`timescale 1ns/1ps
module ocpa_clk_rx (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // watched pin
    input  wire logic        clk_in,
    // last full period
    output logic      [33:0] hi_len,
    output logic      [33:0] lo_len,
    output logic             per_done
);
    logic        prev_q;
    logic [33:0] hi_q;
    logic [33:0] lo_q;
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            {prev_q, hi_q, lo_q, hi_len, lo_len, per_done} <= '0;
        end else begin
            prev_q   <= clk_in;
            per_done <= clk_in && !prev_q;
            if (clk_in && !prev_q) begin
                hi_len <= hi_q;
                lo_len <= lo_q;
                hi_q   <= 34'h1;
                lo_q   <= 34'h0;
            end else if (clk_in) begin
                hi_q <= hi_q + 34'h1;
            end else begin
                lo_q <= lo_q + 34'h1;
            end
        end
    end
endmodule

// >>> sim/ocpa_stage_test.sv
// self-checking bench for the coarse phase adjust stage
// assumes stage, checker and receiver model compiled before it
`timescale 1ns/1ps
`include "ocpa_map.vh"
module ocpa_stage_test;
    logic        clock, nrst, wr, rd, pd, tp, cp, dm, serr;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, seed, dv, hw, ctl, d;
    logic [1:0]  sw, imp;
    logic [2:0]  cm, sup;
    logic [33:0] hl, ll, eh, el;
    integer      mismatches, check_count, i, s, cyc = 0;
    ocpa_stage i_ocpa_stage (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata, .true_output_pin(tp),
        .complement_output_pin(cp), .diff_mode(dm), .swing_select(sw), .common_mode_select(cm),
        .supply_level_select(sup), .impedance_select(imp), .setting_error(serr));
    ocpa_clk_rx i_ocpa_clk_rx (.clock, .nrst, .clk_in(tp), .hi_len(hl), .lo_len(ll), .per_done(pd));
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input [33:0] got, input [33:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task wr_reg(input [3:0] a, input [31:0] v);
        @(posedge clock);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task rd_reg(input [3:0] a, output [31:0] v);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task next_per;
        do @(posedge clock); while (pd !== 1'b1);
    endtask
    function automatic [67:0] exp_per(input [31:0] v, input [31:0] h0, input integer sh);
        logic        pl;
        logic [33:0] h, l, m, dh, dl;
        pl = h0 != 0 && h0 < v;
        h  = pl ? h0 : v >> 1;
        l  = v - h;
        m  = sh < 0 ? -sh : sh;
        dh = pl ? 34'h0 : m >> 1;
        dl = m - dh;
        if (sh < 0) begin
            h = h < dh + 2 ? 34'h2 : h - dh;
            l = l < dl + 2 ? 34'h2 : l - dl;
        end else begin
            h = h + dh;
            l = l + dl;
        end
        return {h, l};
    endfunction
    task per_chk(input [31:0] v, input [31:0] h0, input integer sh);
        {eh, el} = exp_per(v, h0, sh);
        next_per;
        chk(hl, eh);
        chk(ll, el);
    endtask
    task set_div(input [31:0] v, input [31:0] h0);
        wr_reg(`OCPA_REG_DIV, v);
        wr_reg(`OCPA_REG_HIGH, h0);
        repeat (3) next_per;
        rd_reg(`OCPA_REG_ACTIVE_DIV, d);
        chk(d, v);
    endtask
    task shift_chk(input [31:0] v, input [31:0] h0, input integer sh);
        next_per;
        wr_reg(`OCPA_REG_SHIFT, sh);
        rd_reg(`OCPA_REG_STATUS, d);
        chk(d[1], 34'h1);
        rd_reg(`OCPA_REG_SHIFT, d);
        chk(d, sh[31:0]);
        per_chk(v, h0, 0);
        per_chk(v, h0, sh);
        per_chk(v, h0, 0);
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
    end
    initial begin
        seed = 32'hFA44E5D2;
        {nrst, wr, rd, addr, wdata} = '0;
        mismatches = 0;
        check_count = 0;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        rd_reg(`OCPA_REG_DIV, d);
        chk(d, `OCPA_DIV_RST);
        wr_reg(4'hF, 32'hFFFFFFFF);
        rd_reg(4'hF, d);
        chk(d, 34'h0);
        chk({dm, sw, cm, sup, imp}, 34'h0);
        wr_reg(`OCPA_REG_BUF_CTRL, 32'h1000);
        repeat (3) next_per;
        per_chk(10, 0, 0);
        for (i = 0; i < 6; i = i + 1) begin
            dv = 32'h5 + ($random(seed) & 32'hF);
            hw = i[0] ? 32'h2 + (dv >> 2) : 32'h0;
            set_div(dv, hw);
            per_chk(dv, hw, 0);
        end
        $display("test periods done");
        for (i = 0; i < 8; i = i + 1) begin
            dv = 32'h8 + ($random(seed) & 32'hF);
            hw = i[0] ? 32'h3 : 32'h0;
            s  = $random(seed) % 12;
            set_div(dv, hw);
            shift_chk(dv, hw, s);
        end
        shift_chk(dv, hw, -100);
        set_div(8, 0);
        shift_chk(8, 0, -100);
        shift_chk(8, 0, 41);
        set_div(4, 0);
        wr_reg(`OCPA_REG_SHIFT, 6);
        per_chk(4, 0, 0);
        per_chk(4, 0, 0);
        rd_reg(`OCPA_REG_STATUS, d);
        chk(d[3], 34'h1);
        $display("test shifts done");
        for (i = 0; i < 12; i = i + 1) begin
            ctl = 32'h1000 | ($random(seed) & 32'hC73) | (i[1:0] << 2) | ((i % 5) << 7);
            wr_reg(`OCPA_REG_BUF_CTRL, ctl);
            next_per;
            #1 chk(sw, ctl[3:2]);
            chk(cm, ctl[6:4]);
            chk({sup, imp}, {ctl[9:7], ctl[11:10]});
            chk(serr, ctl[0] && (ctl[9:7] == 3'h3 || ctl[9:7] == 3'h4));
            chk(cp, tp ^ (ctl[0] || ctl[1]));
        end
        $display("test buffer done");
        report_and_stop;
    end
endmodule
